// ===== hw/chgcfg_pkg.sv
package chgcfg_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_FAST_CHARGE = 8'h02;
    localparam logic [7:0] ADDR_PRE_TERM    = 8'h03;
    localparam logic [7:0] ADDR_BATT_VOLT   = 8'h04;
    localparam logic [7:0] ADDR_TIMER_CTRL  = 8'h05;
    localparam int unsigned NUM_REGS        = 4;
    localparam logic [7:0] ADDR_BASE        = 8'h02;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RST_FAST_CHARGE = 8'h3f;
    localparam logic [7:0] RST_PRE_TERM    = 8'h11;
    localparam logic [7:0] RST_BATT_VOLT   = 8'ha1;
    localparam logic [7:0] RST_TIMER_CTRL  = 8'h3b;

    // ----------------------------------------
    // Field positions and masks
    // ----------------------------------------
    localparam logic [7:0] VOLT_WRITE_MASK = 8'hfd;
    localparam logic [7:0] TIMER_DOG_MASK  = 8'he0;
    localparam int unsigned TMR_DISCHG_BIT = 7;
    localparam int unsigned TMR_DOG_HI     = 6;
    localparam int unsigned TMR_DOG_LO     = 5;
    localparam int unsigned TMR_TERM_BIT   = 4;
    localparam int unsigned TMR_SAFETY_BIT = 3;
    localparam int unsigned TMR_FAST_HI    = 2;
    localparam int unsigned TMR_FAST_LO    = 1;
    localparam int unsigned TMR_PRE_BIT    = 0;
    localparam logic [1:0] DOG_OFF         = 2'h0;
endpackage

// ===== hw/chgcfg_regmem.sv
`timescale 1ns/1ps
`default_nettype none
// Four-byte register storage with registered read data
module chgcfg_regmem
    import chgcfg_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // Write port
    input  wire logic       wr_en,
    input  wire logic [1:0] wr_idx,
    input  wire logic [7:0] wr_data,
    // Default load, all words in one cycle
    input  wire logic       load_all,
    input  wire logic       keep_dog,
    // Read port
    input  wire logic [1:0] rd_idx,
    output logic      [7:0] rd_data,
    // All words in parallel
    output logic      [7:0] words [NUM_REGS]
);
    import chgcfg_pkg::*;

    localparam logic [7:0] DEFAULTS [NUM_REGS] =
        '{RST_FAST_CHARGE, RST_PRE_TERM, RST_BATT_VOLT, RST_TIMER_CTRL};

    typedef struct packed {
        logic [NUM_REGS-1:0][7:0] mem;
        logic [7:0]               rd;
    } chgcfg_mem_s;

    chgcfg_mem_s st;
    chgcfg_mem_s next_st;

    // Next-state: defaults win over a write in the same cycle
    always_comb begin
        next_st = st;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (load_all) begin
                if (i == NUM_REGS - 1 && keep_dog) begin
                    next_st.mem[i] = (st.mem[i] & TIMER_DOG_MASK)
                                   | (DEFAULTS[i] & ~TIMER_DOG_MASK);
                end else begin
                    next_st.mem[i] = DEFAULTS[i];
                end
            end else if (wr_en && wr_idx == i[1:0]) begin
                next_st.mem[i] = wr_data;
            end
        end
        next_st.rd = next_st.mem[rd_idx];
    end

    // State register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st.mem <= {RST_TIMER_CTRL, RST_BATT_VOLT, RST_PRE_TERM, RST_FAST_CHARGE};
            st.rd  <= 8'h00;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    always_comb begin
        rd_data = st.rd;
        for (int i = 0; i < NUM_REGS; i++) begin
            words[i] = st.mem[i];
        end
    end
endmodule
`default_nettype wire

// ===== hw/chgcfg_regs.sv
// How it works
// - Fast-charge code is eight bits, 2mA per step plus 2mA, defaulting to 0x3f.
// - Pre-charge code is the upper nibble of its register, defaulting to 0001.
// - End current code is the lower nibble of that register, defaulting to 0001.
// - Cell target voltage sits in bits 7:2 of the voltage register, default 101000.
// - Voltage bit 0 picks the recharge drop, default 1, and bit 1 is reserved.
// - Timer bit 7 enables the watchdog in discharge mode, default cleared.
// - A period code of 00 keeps the watchdog off whatever bit 7 says.
// - Timer bit 4 allows charge termination, default set.
// - Timer bit 3 enables the safety timer and bits 2:1 pick its length, default 1 and 01.
// - Timer bit 0 picks the pre-charge exit level, default 1.
// - Register reset restores all fields; expiry restores all but bits 7:5 of the timer.
// - Expiry of the watchdog sets a read-only fault status bit.
`timescale 1ns/1ps
`default_nettype none
module chgcfg_regs
    import chgcfg_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       arst_n,
    // Register access from the serial front end
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_hit,
    // Reset events
    input  wire logic       reg_reset_req,
    input  wire logic       dog_timer_expiry,
    input  wire logic       fault_read_clear,
    // Configuration outputs
    output logic      [7:0] fast_charge_code,
    output logic      [3:0] precharge_current_code,
    output logic      [3:0] end_current_code,
    output logic      [5:0] cell_target_voltage,
    output logic            recharge_drop_select,
    output logic            discharge_dog_enable,
    output logic      [1:0] dog_period_code,
    output logic            dog_active,
    output logic            term_enable,
    output logic            safety_timer_enable,
    output logic      [1:0] fast_charge_time_limit,
    output logic            precharge_exit_level,
    output logic            dog_fault
);
    import chgcfg_pkg::*;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic [1:0] rst_sync;
    logic       rst_n;

    // Two-stage release of the async reset
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic logic in_map(input logic [7:0] a);
        in_map = (a >= ADDR_FAST_CHARGE) && (a <= ADDR_TIMER_CTRL);
    endfunction

    logic [1:0] idx;
    logic [7:0] wr_word;
    logic [7:0] rd_word;
    logic [7:0] words [NUM_REGS];
    logic       wr_ok;
    logic       load_all;

    assign idx      = 2'(reg_addr - ADDR_BASE);
    assign wr_ok    = reg_wr && in_map(reg_addr);
    assign load_all = reg_reset_req || dog_timer_expiry;
    // Reserved voltage bit never stored
    assign wr_word  = (reg_addr == ADDR_BATT_VOLT) ?
                      (reg_wdata & VOLT_WRITE_MASK) : reg_wdata;

    chgcfg_regmem u_mem (
        .clock    (clock),
        .rst_n    (rst_n),
        .wr_en    (wr_ok),
        .wr_idx   (idx),
        .wr_data  (wr_word),
        .load_all (load_all),
        .keep_dog (dog_timer_expiry && !reg_reset_req),
        .rd_idx   (idx),
        .rd_data  (rd_word),
        .words    (words)
    );

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] rdata;
        logic       hit;
        logic       fault;
        logic [7:0] w0;
        logic [7:0] w1;
        logic [7:0] w2;
        logic [7:0] w3;
        logic       dog_on;
    } chgcfg_out_s;

    chgcfg_out_s st;
    chgcfg_out_s next_st;
    logic        rd_d;

    // Read strobe delayed to meet registered memory data
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_d <= 1'b0;
        end else begin
            rd_d <= reg_rd && in_map(reg_addr);
        end
    end

    // Next-state of outputs
    always_comb begin
        next_st       = st;
        next_st.hit   = rd_d;
        if (rd_d) begin
            next_st.rdata = rd_word;
        end
        // Expiry set wins over a clear
        if (dog_timer_expiry) begin
            next_st.fault = 1'b1;
        end else if (fault_read_clear) begin
            next_st.fault = 1'b0;
        end
        next_st.w0 = words[0];
        next_st.w1 = words[1];
        next_st.w2 = words[2];
        next_st.w3 = words[3];
        // Period decoded ahead so the active flag leaves a flop
        next_st.dog_on = words[3][TMR_DOG_HI:TMR_DOG_LO] != DOG_OFF;
    end

    // Output state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= {8'h00, 1'b0, 1'b0, RST_FAST_CHARGE, RST_PRE_TERM,
                   RST_BATT_VOLT, RST_TIMER_CTRL,
                   RST_TIMER_CTRL[TMR_DOG_HI:TMR_DOG_LO] != DOG_OFF};
        end else begin
            st <= next_st;
        end
    end

    // Field outputs
    always_comb begin
        reg_rdata              = st.rdata;
        reg_hit                = st.hit;
        dog_fault              = st.fault;
        fast_charge_code       = st.w0;
        precharge_current_code = st.w1[7:4];
        end_current_code       = st.w1[3:0];
        cell_target_voltage    = st.w2[7:2];
        recharge_drop_select   = st.w2[0];
        discharge_dog_enable   = st.w3[TMR_DISCHG_BIT];
        dog_period_code        = st.w3[TMR_DOG_HI:TMR_DOG_LO];
        dog_active             = st.dog_on;
        term_enable            = st.w3[TMR_TERM_BIT];
        safety_timer_enable    = st.w3[TMR_SAFETY_BIT];
        fast_charge_time_limit = st.w3[TMR_FAST_HI:TMR_FAST_LO];
        precharge_exit_level   = st.w3[TMR_PRE_BIT];
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_reset_event;
        reg_reset_req;
    endsequence

    a_rst_defaults: assert property (@(posedge clock) disable iff (!rst_n)
        s_reset_event |-> ##2 (st.w0 == RST_FAST_CHARGE && st.w1 == RST_PRE_TERM
                               && st.w2 == RST_BATT_VOLT && st.w3 == RST_TIMER_CTRL))
        else $error("register reset did not restore defaults");
    a_dog_keeps: assert property (@(posedge clock) disable iff (!rst_n)
        (dog_timer_expiry && !reg_reset_req) |-> ##2
            (st.w3[TMR_DISCHG_BIT:TMR_DOG_LO] == $past(st.w3[TMR_DISCHG_BIT:TMR_DOG_LO], 1)))
        else $error("watchdog expiry altered watchdog fields");
    a_dog_fault_set: assert property (@(posedge clock) disable iff (!rst_n)
        dog_timer_expiry |=> dog_fault)
        else $error("fault bit not set on expiry");
    a_resv_zero: assert property (@(posedge clock) disable iff (!rst_n)
        !st.w2[1])
        else $error("reserved voltage bit is set");
    a_period_off: assert property (@(posedge clock) disable iff (!rst_n)
        (dog_period_code == DOG_OFF) |-> !dog_active)
        else $error("watchdog active with period off");
    a_write_lands: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_ok && !load_all && reg_addr == ADDR_FAST_CHARGE) |-> ##2
            (fast_charge_code == $past(reg_wdata, 2)))
        else $error("fast charge write lost");
    a_term_write: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_ok && !load_all && reg_addr == ADDR_TIMER_CTRL) |-> ##2
            (term_enable == $past(reg_wdata[TMR_TERM_BIT], 2)))
        else $error("termination enable write lost");
    a_pre_exit: assert property (@(posedge clock) disable iff (!rst_n)
        reg_reset_req |-> ##2 (precharge_exit_level && safety_timer_enable
                               && fast_charge_time_limit == 2'h1))
        else $error("timer defaults wrong after reset");

    sequence s_volt_read;
        reg_rd && reg_addr == ADDR_BATT_VOLT;
    endsequence

    a_resv_read: assert property (@(posedge clock) disable iff (!rst_n)
        s_volt_read |-> ##2 (reg_hit && !reg_rdata[1]))
        else $error("reserved voltage bit read back as one");
endmodule
`default_nettype wire

// ===== bench/chgcfg_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host stand-in issuing single register cycles on the front-end strobes
module chgcfg_host (
    // Clock
    input  wire logic       clock,
    // Request lines
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    // Read answer
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_hit
);
    // Idle bus at time zero
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end
    // One write strobe; lines scrambled afterwards so stale values never help
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clock);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
    // One read strobe; answer awaited for a bounded number of cycles
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic hit);
        @(negedge clock);
        reg_rd   = 1'b1;
        reg_addr = a;
        @(negedge clock);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        hit      = 1'b0;
        d        = 8'h00;
        repeat (3) begin
            @(negedge clock);
            if (reg_hit === 1'b1) begin
                hit = 1'b1;
                d   = reg_rdata;
            end
        end
    endtask
endmodule
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import chgcfg_pkg::*;
    logic       clock, arst_n, reg_wr, reg_rd, reg_hit, reg_reset_req;
    logic       dog_timer_expiry, fault_read_clear, dog_fault, dog_active;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, fast_charge_code, a, d, rd_d;
    logic [3:0] precharge_current_code, end_current_code;
    logic [5:0] cell_target_voltage;
    logic       recharge_drop_select, discharge_dog_enable, term_enable, hit;
    logic       safety_timer_enable, precharge_exit_level;
    logic [1:0] dog_period_code, fast_charge_time_limit;
    logic [31:0] sh;
    int         n_errors, tests_run;
    // Defaults worked out field by field
    localparam logic [31:0] DEF = {8'h3f, 4'h1, 4'h1, 6'b101000, 1'b0, 1'b1,
                                   1'b0, 2'b01, 1'b1, 1'b1, 2'b01, 1'b1};
    chgcfg_regs dut (.clock, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_hit, .reg_reset_req, .dog_timer_expiry, .fault_read_clear,
        .fast_charge_code, .precharge_current_code, .end_current_code,
        .cell_target_voltage, .recharge_drop_select, .discharge_dog_enable,
        .dog_period_code, .dog_active, .term_enable, .safety_timer_enable,
        .fast_charge_time_limit, .precharge_exit_level, .dog_fault);
    chgcfg_host host (.clock, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_hit);
    // Clock and watchdog
    always #50 clock = ~clock;
    initial begin
        #(3000 * 100);
        n_errors++;
        wrap_up();
    end
    // Field outputs packed like the four registers
    function automatic logic [31:0] cur();
        return {fast_charge_code, precharge_current_code, end_current_code,
                cell_target_voltage, 1'b0, recharge_drop_select, discharge_dog_enable,
                dog_period_code, term_enable, safety_timer_enable,
                fast_charge_time_limit, precharge_exit_level};
    endfunction
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Pulse one event and watch that fields never show a mixed state
    task automatic ev(input bit expiry, input logic [31:0] nxt);
        logic [31:0] old;
        old = sh;
        sh  = nxt;
        @(negedge clock);
        if (expiry) begin
            dog_timer_expiry = 1'b1;
            fault_read_clear = 1'b1;
        end else begin
            reg_reset_req = 1'b1;
        end
        @(negedge clock);
        dog_timer_expiry = 1'b0;
        reg_reset_req    = 1'b0;
        fault_read_clear = 1'b0;
        repeat (4) begin
            chk("load_atomic", cur() === old || cur() === sh, 1);
            @(negedge clock);
        end
        chk("fields_after_event", cur(), sh);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        clock = 0; arst_n = 0; reg_reset_req = 0; dog_timer_expiry = 0;
        fault_read_clear = 0; n_errors = 0; tests_run = 0;
        void'($urandom(67));
        repeat (16) @(negedge clock);
        arst_n = 1'b1;
        repeat (4) @(negedge clock);
        sh = DEF;
        chk("reset_fields", cur(), sh);
        chk("reset_fault", dog_fault, 0);
        chk("reset_dog", dog_active, 1);
        // Corner writes first, then random traffic including unmapped addresses
        for (int i = 0; i < 28; i++) begin
            case (i)
                0: {a, d} = 16'h04ff;
                1: {a, d} = 16'h059e;
                2: {a, d} = 16'h0200;
                3: {a, d} = 16'h02ff;
                default: begin
                    a = 8'($urandom_range(7, 0));
                    d = 8'($urandom);
                end
            endcase
            host.wr(a, d);
            if (a >= 8'h02 && a <= 8'h05) sh[8 * (5 - a) +: 8] = (a == 8'h04) ? d & 8'hfd : d;
            host.rd(a, rd_d, hit);
            chk("read_hit", hit, a >= 8'h02 && a <= 8'h05);
            if (hit === 1'b1) chk("read_data", rd_d, sh[8 * (5 - a) +: 8]);
            chk("fields", cur(), sh);
            chk("dog_active", dog_active, sh[6:5] != 2'b00);
        end
        // Expiry keeps the watchdog controls and sets the fault over a clear
        host.wr(8'h05, 8'hc0);
        sh[7:0] = 8'hc0;
        ev(1'b1, {DEF[31:8], sh[7:5], DEF[4:0]});
        chk("fault_set", dog_fault, 1);
        @(negedge clock);
        fault_read_clear = 1'b1;
        @(negedge clock);
        fault_read_clear = 1'b0;
        repeat (2) @(negedge clock);
        chk("fault_clear", dog_fault, 0);
        // Register reset restores everything
        host.wr(8'h03, 8'h7e);
        sh[23:16] = 8'h7e;
        ev(1'b0, DEF);
        chk("dog_after_reset", dog_active, 1);
        wrap_up();
    end
endmodule
`default_nettype wire
